// File: pkg/sbst_pkg.sv
/*
 * Constants shared by both ends of the memory boundary-scan test port:
 * state encoding, instruction codes, register lengths, identity code.
 * Assumes nothing of its surroundings.
 */
package sbst_pkg;
   typedef enum logic [3:0] {
      SBST_RESET = 4'h0, SBST_IDLE = 4'h1, SBST_SEL_DR = 4'h3,
      SBST_CAP_DR = 4'h2, SBST_SHIFT_DR = 4'h6, SBST_EXIT1_DR = 4'h7,
      SBST_PAUSE_DR = 4'h5, SBST_EXIT2_DR = 4'h4, SBST_UPD_DR = 4'hC,
      SBST_SEL_IR = 4'hD, SBST_CAP_IR = 4'hF, SBST_SHIFT_IR = 4'hE,
      SBST_EXIT1_IR = 4'hA, SBST_PAUSE_IR = 4'hB, SBST_EXIT2_IR = 4'h9,
      SBST_UPD_IR = 4'h8
   } sbst_state_e;
   localparam int IR_LEN = 3;
   localparam int ID_LEN = 32;
   localparam int BSR_LEN = 71;
   localparam logic [2:0] INS_EXTEST = 3'h0;
   localparam logic [2:0] INS_IDCODE = 3'h1;
   localparam logic [2:0] INS_SAMPLEZ = 3'h2;
   localparam logic [2:0] INS_SAMPLE = 3'h4;
   localparam logic [2:0] INS_BYPASS = 3'h7;
   localparam logic [1:0] IR_CAPTURE = 2'h1;
   // identity code value is arbitrary; bit 0 is the presence marker
   localparam logic [31:0] ID_CODE = 32'h1234_5679;
   localparam int RESET_TMS_EDGES = 5;
   // host divides its clock by twice this for the link clock (250/16 < 20 MHz)
   localparam int TCK_HALF_DIV = 8;
   localparam logic [3:0] TCK_HALF_MAX = 4'h7;
   localparam logic [1:0] SYNC_ONES = 2'h3;
   localparam logic [1:0] SYNC_ZEROS = 2'h0;

   function automatic sbst_state_e sbst_next(sbst_state_e s, logic tms);
      case (s)
         SBST_RESET: sbst_next = tms ? SBST_RESET : SBST_IDLE;
         SBST_IDLE: sbst_next = tms ? SBST_SEL_DR : SBST_IDLE;
         SBST_SEL_DR: sbst_next = tms ? SBST_SEL_IR : SBST_CAP_DR;
         SBST_CAP_DR: sbst_next = tms ? SBST_EXIT1_DR : SBST_SHIFT_DR;
         SBST_SHIFT_DR: sbst_next = tms ? SBST_EXIT1_DR : SBST_SHIFT_DR;
         SBST_EXIT1_DR: sbst_next = tms ? SBST_UPD_DR : SBST_PAUSE_DR;
         SBST_PAUSE_DR: sbst_next = tms ? SBST_EXIT2_DR : SBST_PAUSE_DR;
         SBST_EXIT2_DR: sbst_next = tms ? SBST_UPD_DR : SBST_SHIFT_DR;
         SBST_UPD_DR: sbst_next = tms ? SBST_SEL_DR : SBST_IDLE;
         SBST_SEL_IR: sbst_next = tms ? SBST_RESET : SBST_CAP_IR;
         SBST_CAP_IR: sbst_next = tms ? SBST_EXIT1_IR : SBST_SHIFT_IR;
         SBST_SHIFT_IR: sbst_next = tms ? SBST_EXIT1_IR : SBST_SHIFT_IR;
         SBST_EXIT1_IR: sbst_next = tms ? SBST_UPD_IR : SBST_PAUSE_IR;
         SBST_PAUSE_IR: sbst_next = tms ? SBST_EXIT2_IR : SBST_PAUSE_IR;
         SBST_EXIT2_IR: sbst_next = tms ? SBST_UPD_IR : SBST_SHIFT_IR;
         SBST_UPD_IR: sbst_next = tms ? SBST_SEL_DR : SBST_IDLE;
         default: sbst_next = SBST_RESET;
      endcase
   endfunction
endpackage

// File: pkg/sbst_if.sv
/*
 * Scan link between the host controller and the memory test port.
 * Assumes tdo is meaningful only while tdo_oe is high.
 */
`timescale 1ns/1ps
interface sbst_if;
   logic tck;
   logic tms;
   logic tdi;
   logic tdo;
   logic tdo_oe;
   modport dev (input tck, input tms, input tdi, output tdo,
      output tdo_oe);
   modport host (output tck, output tms, output tdi, input tdo,
      input tdo_oe);
endinterface

// File: logic/sbst_dev.sv
/*
 * Device end: test port controller, instruction, bypass, identity and
 * boundary registers. Link clock arrives as a pin and is oversampled by
 * clk_in; link inputs pass a three-stage synchroniser.
 */
`timescale 1ns/1ps
// Behaviour
// - sample tms/tdi on rise, tdo on fall
// - five tms-high rising edges reset controller
// - reset puts controller in reset, tdo off
// - three-bit instruction, identity on reset
// - capture-ir loads 01 into low bits
// - shift in at msb, out at lsb
// - drive tdo only in shift states
// - instruction selects exactly one data register
// - one-bit bypass cleared, path under bypass
// - boundary captures pins, then shifts
// - identity register captures fixed 32-bit code
// - new instruction only at update-ir
// - all-zeros captures like sample, outputs off
// - identity shifts out, memory unaffected
// - sample-z uses boundary, outputs off
// - sample snapshots pins, shifts them out
// - update-dr under sample changes nothing
// - no driving memory, no preload
// - host issues only five implemented codes
// - host keeps link clock at most 20 MHz
// - decode 000 external, 001 identity, 010 sample-z
// - identity bit zero reads one
// - boundary register is 71 bits
module sbst_dev (
   // system
   input wire logic clk_in,
   input wire logic rst_n_in,
   // link
   sbst_if.dev link,
   // memory side
   input wire logic [sbst_pkg::BSR_LEN-1:0] pins_in,
   output logic mem_hiz_out,
   output sbst_pkg::sbst_state_e state_out
);
   logic [2:0] tck_s, tms_s, tdi_s;
   logic tck_q, tms_q, tdi_q;
   sbst_pkg::sbst_state_e state;
   logic [sbst_pkg::IR_LEN-1:0] ir_sh, ir;
   logic bypass;
   logic [sbst_pkg::ID_LEN-1:0] id_sh;
   logic [sbst_pkg::BSR_LEN-1:0] bsr;
   logic [sbst_pkg::BSR_LEN-1:0] pins_q;
   logic [sbst_pkg::BSR_LEN-1:0] pins_s1, pins_s2, pins_s3, pins_agree;
   logic tdo, tdo_oe, scan_bit;
   logic rise, fall;

   // a change is accepted once the last two stages agree
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         tck_s <= 3'h0;
         tms_s <= 3'h7;
         tdi_s <= 3'h7;
         tck_q <= 1'b0;
         tms_q <= 1'b1;
         tdi_q <= 1'b1;
      end else begin
         tck_s <= {tck_s[1:0], link.tck};
         tms_s <= {tms_s[1:0], link.tms};
         tdi_s <= {tdi_s[1:0], link.tdi};
         if (tck_s[2:1] == sbst_pkg::SYNC_ONES) begin
            tck_q <= 1'b1;
         end else if (tck_s[2:1] == sbst_pkg::SYNC_ZEROS) begin
            tck_q <= 1'b0;
         end
         if (tms_s[2] == tms_s[1]) begin
            tms_q <= tms_s[2];
         end
         if (tdi_s[2] == tdi_s[1]) begin
            tdi_q <= tdi_s[2];
         end
      end
   end

   // pins belong to the memory clock; three stages, a bit counts once the
   // last two agree, and a bit still settling keeps its old level
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         pins_s1 <= '0;
         pins_s2 <= '0;
         pins_s3 <= '0;
         pins_q <= '0;
      end else begin
         pins_s1 <= pins_in;
         pins_s2 <= pins_s1;
         pins_s3 <= pins_s2;
         pins_q <= (pins_s3 & pins_agree) | (pins_q & ~pins_agree);
      end
   end

   assign pins_agree = ~(pins_s2 ^ pins_s3);
   assign rise = (tck_s[2:1] == sbst_pkg::SYNC_ONES) && !tck_q;
   assign fall = (tck_s[2:1] == sbst_pkg::SYNC_ZEROS) && tck_q;

   // controller; five tms-high rises reach reset from anywhere
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         state <= sbst_pkg::SBST_RESET;
      end else if (rise) begin
         state <= sbst_pkg::sbst_next(state, tms_q);
      end
   end

   // instruction register
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         ir_sh <= sbst_pkg::INS_IDCODE;
         ir <= sbst_pkg::INS_IDCODE;
      end else if (rise) begin
         case (state)
            sbst_pkg::SBST_RESET: begin
               ir <= sbst_pkg::INS_IDCODE;
            end
            sbst_pkg::SBST_CAP_IR: begin
               ir_sh <= {1'b0, sbst_pkg::IR_CAPTURE};
            end
            sbst_pkg::SBST_SHIFT_IR: begin
               ir_sh <= {tdi_q, ir_sh[sbst_pkg::IR_LEN-1:1]};
            end
            sbst_pkg::SBST_UPD_IR: begin
               ir <= ir_sh;
            end
            default: begin
            end
         endcase
      end
   end

   // data registers; update-dr does nothing since preload is absent
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         bypass <= 1'b0;
         id_sh <= sbst_pkg::ID_CODE;
         bsr <= '0;
      end else begin
         if (rise && state == sbst_pkg::SBST_CAP_DR) begin
            case (ir)
               sbst_pkg::INS_IDCODE: begin
                  id_sh <= sbst_pkg::ID_CODE;
               end
               sbst_pkg::INS_EXTEST, sbst_pkg::INS_SAMPLEZ,
               sbst_pkg::INS_SAMPLE: begin
                  bsr <= pins_q;
               end
               default: begin
                  bypass <= 1'b0;
               end
            endcase
         end else if (rise && state == sbst_pkg::SBST_SHIFT_DR) begin
            case (ir)
               sbst_pkg::INS_IDCODE: begin
                  id_sh <= {tdi_q, id_sh[sbst_pkg::ID_LEN-1:1]};
               end
               sbst_pkg::INS_EXTEST, sbst_pkg::INS_SAMPLEZ,
               sbst_pkg::INS_SAMPLE: begin
                  bsr <= {tdi_q, bsr[sbst_pkg::BSR_LEN-1:1]};
               end
               default: begin
                  bypass <= tdi_q;
               end
            endcase
         end
      end
   end

   always_comb begin
      case (ir)
         sbst_pkg::INS_IDCODE: scan_bit = id_sh[0];
         sbst_pkg::INS_EXTEST, sbst_pkg::INS_SAMPLEZ,
         sbst_pkg::INS_SAMPLE: scan_bit = bsr[0];
         default: scan_bit = bypass;
      endcase
   end

   // output moves on the falling link edge only
   // tdo still follows the scan bit on every fall while released; the host qualifies by tdo_oe
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         tdo <= 1'b0;
         tdo_oe <= 1'b0;
      end else if (fall) begin
         tdo_oe <= (state == sbst_pkg::SBST_SHIFT_DR) ||
            (state == sbst_pkg::SBST_SHIFT_IR);
         tdo <= (state == sbst_pkg::SBST_SHIFT_IR) ? ir_sh[0] : scan_bit;
      end
   end

   // memory outputs forced off under extest and sample-z; nothing is ever driven into the memory
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         mem_hiz_out <= 1'b0;
      end else begin
         mem_hiz_out <= (ir == sbst_pkg::INS_EXTEST) ||
            (ir == sbst_pkg::INS_SAMPLEZ);
      end
   end

   assign link.tdo = tdo;
   assign link.tdo_oe = tdo_oe;
   assign state_out = state;
endmodule

// File: logic/sbst_host.sv
/*
 * Host end: makes the link clock by dividing clk_in, drives tms/tdi
 * from a user command, and samples tdo on the rising link edge.
 * Assumes the user asks for at most one bit per link cycle.
 */
`timescale 1ns/1ps
module sbst_host (
   // system
   input wire logic clk_in,
   input wire logic rst_n_in,
   // link
   sbst_if.host link,
   // user command: one link clock cycle per request
   input wire logic req_in,
   input wire logic tms_in,
   input wire logic tdi_in,
   output logic ready_out,
   output logic done_out,
   output logic tdo_out,
   output logic tdo_valid_out
);
   logic [3:0] div;
   logic tck, busy, tms, tdi;
   logic [2:0] tdo_s, oe_s;
   logic tdo_q, oe_q;

   // tck period is 2*TCK_HALF_DIV clk cycles, within 20 MHz
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         div <= 4'h0;
         tck <= 1'b0;
         busy <= 1'b0;
         tms <= 1'b1;
         tdi <= 1'b1;
         done_out <= 1'b0;
         tdo_out <= 1'b0;
         tdo_valid_out <= 1'b0;
      end else begin
         done_out <= 1'b0;
         if (!busy && req_in) begin
            busy <= 1'b1;
            tms <= tms_in;
            tdi <= tdi_in;
            div <= 4'h0;
         end else if (busy) begin
            div <= div + 4'h1;
            if (div == sbst_pkg::TCK_HALF_MAX) begin
               tck <= ~tck;
               div <= 4'h0;
               if (tck) begin
                  busy <= 1'b0;
                  done_out <= 1'b1;
               end else begin
                  // device drove tdo on the earlier fall; sample it now
                  tdo_out <= tdo_q;
                  tdo_valid_out <= oe_q;
               end
            end
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         tdo_s <= 3'h0;
         oe_s <= 3'h0;
         tdo_q <= 1'b0;
         oe_q <= 1'b0;
      end else begin
         tdo_s <= {tdo_s[1:0], link.tdo};
         oe_s <= {oe_s[1:0], link.tdo_oe};
         // a level counts once the last two stages agree
         if (tdo_s[2] == tdo_s[1]) begin
            tdo_q <= tdo_s[2];
         end
         if (oe_s[2] == oe_s[1]) begin
            oe_q <= oe_s[2];
         end
      end
   end

   assign ready_out = !busy;
   assign link.tck = tck;
   assign link.tms = tms;
   assign link.tdi = tdi;
endmodule

// File: test/sbst_chk_sva.sv
/*
 * Link checker for the memory boundary-scan test port.
 * Assumes it is instantiated beside the interface that joins both ends.
 */
`timescale 1ns/1ps
module sbst_chk (
   // system
   input logic clk_in,
   input logic rst_n_in,
   // link
   input logic tck,
   input logic tms,
   input logic tdi,
   input logic tdo,
   input logic tdo_oe
);
   logic tck_d;
   logic last_tms;
   logic [2:0] ones;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   always_ff @(posedge clk_in) begin
      tck_d <= tck;
   end
   // tms seen at the last link rise, and a saturating run of tms-high rises
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         last_tms <= 1'h1;
         ones <= 3'h0;
      end else if (tck && !tck_d) begin
         last_tms <= tms;
         ones <= tms ? ((ones == 3'h7) ? ones : ones + 3'h1) : 3'h0;
      end
   end
   property p_tdo_on_low;
      $changed(tdo) |-> !tck;
   endproperty
   a_tdo_on_low: assert property (p_tdo_on_low)
      else $error("data out moved while link clock high");
   property p_oe_on_low;
      $changed(tdo_oe) |-> !tck;
   endproperty
   a_oe_on_low: assert property (p_oe_on_low)
      else $error("output enable moved while link clock high");
   property p_oe_rise;
      $rose(tdo_oe) |-> !last_tms;
   endproperty
   a_oe_rise: assert property (p_oe_rise)
      else $error("output enabled without entering a shift state");
   property p_oe_fall;
      $fell(tdo_oe) |-> last_tms;
   endproperty
   a_oe_fall: assert property (p_oe_fall)
      else $error("output released without leaving a shift state");
   property p_rst_quiet;
      $rose(rst_n_in) |-> !tdo_oe;
   endproperty
   a_rst_quiet: assert property (p_rst_quiet)
      else $error("data out driven after reset");
   property p_five_ones;
      ($rose(tck) && tms && ones == 3'h4) |-> ##14 !tdo_oe;
   endproperty
   a_five_ones: assert property (p_five_ones)
      else $error("five tms-high edges left data out driven");
   property p_tck_high;
      $rose(tck) |-> tck[*8] ##1 !tck;
   endproperty
   a_tck_high: assert property (p_tck_high)
      else $error("link clock high phase wrong");
   property p_tck_low;
      $fell(tck) |-> (!tck)[*5];
   endproperty
   a_tck_low: assert property (p_tck_low)
      else $error("link clock low phase too short");
   property p_hold;
      $rose(tck) |-> ($stable(tms) && $stable(tdi))[*3];
   endproperty
   a_hold: assert property (p_hold)
      else $error("tms or tdi moved around link rise");
   c_oe: cover property ($rose(tdo_oe));
   c_ones: cover property (ones == 3'h5);
   c_run: cover property ($fell(tdo_oe) ##[1:400] $rose(tdo_oe));
endmodule

// File: test/sbst_tb_top.sv
/*
 * Self-checking bench: host and device ends joined by one link.
 * Assumes a 250 MHz clk_in and synchronous active-low reset.
 */
`timescale 1ns/1ps
module sbst_tb_top;
   logic clk_in = 1'h0;
   logic rst_n_in = 1'h0;
   logic req_in = 1'h0;
   logic tms_in = 1'h1;
   logic tdi_in = 1'h1;
   logic [70:0] pins_in = 71'h55_1234_5678_9abc_def0;
   logic ready_out, done_out, tdo_out, tdo_valid_out, mem_hiz_out;
   sbst_pkg::sbst_state_e state_out;
   int error_cnt = 0;
   int checked = 0;
   logic [70:0] got;
   logic [2:0] codes [3] = '{sbst_pkg::INS_SAMPLE, sbst_pkg::INS_EXTEST,
      sbst_pkg::INS_SAMPLEZ};
   logic hiz [3] = '{1'h0, 1'h1, 1'h1};
   sbst_if link();
   sbst_dev i_sbst_dev (.clk_in(clk_in), .rst_n_in(rst_n_in), .link(link),
      .pins_in(pins_in), .mem_hiz_out(mem_hiz_out), .state_out(state_out));
   sbst_host i_sbst_host (.clk_in(clk_in), .rst_n_in(rst_n_in), .link(link),
      .req_in(req_in), .tms_in(tms_in), .tdi_in(tdi_in),
      .ready_out(ready_out), .done_out(done_out), .tdo_out(tdo_out),
      .tdo_valid_out(tdo_valid_out));
   sbst_chk i_sbst_chk (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .tck(link.tck), .tms(link.tms), .tdi(link.tdi), .tdo(link.tdo),
      .tdo_oe(link.tdo_oe));
   always #2 clk_in = ~clk_in;
   task check(string what, logic [70:0] seen, logic [70:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // one link cycle; polled on the falling edge so done_out has settled
   task bit_op(input logic tms, input logic tdi);
      @(posedge clk_in);
      req_in <= 1'h1;
      tms_in <= tms;
      tdi_in <= tdi;
      @(posedge clk_in);
      req_in <= 1'h0;
      @(negedge clk_in);
      check("busy", ready_out, 1'h0);
      while (done_out !== 1'h1) @(negedge clk_in);
      check("ready", ready_out, 1'h1);
   endtask
   // from idle through one shift of n bits, lsb first, back to idle
   task scan(input logic ir, input int n, input logic [70:0] din,
      output logic [70:0] dout);
      dout = '0;
      bit_op(1'h1, 1'h1);
      if (ir) bit_op(1'h1, 1'h1);
      bit_op(1'h0, 1'h1);
      bit_op(1'h0, 1'h1);
      for (int i = 0; i < n; i++) begin
         bit_op(i == n - 1, din[i]);
         dout[i] = tdo_out;
         check("oe_shift", tdo_valid_out, 1'h1);
      end
      bit_op(1'h1, 1'h1);
      bit_op(1'h0, 1'h1);
      check("oe_idle", tdo_valid_out, 1'h0);
   endtask
   task tally_and_finish;
      $display("checks %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      #200000;
      error_cnt++;
      tally_and_finish();
   end
   initial begin
      repeat (12) @(posedge clk_in);
      rst_n_in <= 1'h1;
      @(negedge clk_in);
      check("state", state_out, sbst_pkg::SBST_RESET);
      check("oe", link.tdo_oe, 1'h0);
      bit_op(1'h0, 1'h1);
      scan(1'h0, 32, 71'h0, got);
      check("id", got, sbst_pkg::ID_CODE);
      check("id_bit0", got[0], 1'h1);
      check("hiz_id", mem_hiz_out, 1'h0);
      scan(1'h1, 3, sbst_pkg::INS_BYPASS, got);
      check("ir_cap", got[1:0], sbst_pkg::IR_CAPTURE);
      scan(1'h0, 3, 71'h5, got);
      check("bypass", got[2:0], 3'h2);
      for (int k = 0; k < 3; k++) begin
         @(posedge clk_in);
         pins_in <= {pins_in[69:0], ~pins_in[70]};
         scan(1'h1, 3, codes[k], got);
         check("hiz", mem_hiz_out, hiz[k]);
         scan(1'h0, 71, 71'h0, got);
         check("bsr", got, pins_in);
         check("hiz_upd", mem_hiz_out, hiz[k]);
      end
      // samplez is still loaded here, so the reset must clear the hold
      repeat (5) bit_op(1'h1, 1'h1);
      @(negedge clk_in);
      check("tap_rst", state_out, sbst_pkg::SBST_RESET);
      check("hiz_rst", mem_hiz_out, 1'h0);
      bit_op(1'h0, 1'h1);
      scan(1'h0, 32, 71'h0, got);
      check("id_rst", got, sbst_pkg::ID_CODE);
      tally_and_finish();
   end
endmodule
